// >>> rtl/chg_pkg.sv
package chg_pkg;
	// system clock
	localparam int unsigned CLK_HZ         = 100_000_000;
	// watchdog window: about one second
	localparam int unsigned WDOG_MS        = 1000;
	localparam int unsigned WDOG_CYCLES    = CLK_HZ / 1000 * WDOG_MS;
	// low-current modulator step: about 40 ms per bit
	localparam int unsigned LC_STEP_MS     = 40;
	localparam int unsigned LC_STEP_CYCLES = CLK_HZ / 1000 * LC_STEP_MS;
	// normal modulator step period
	localparam int unsigned NORM_STEP_NS   = 10;
	localparam int unsigned NORM_STEP_CYC  = (CLK_HZ / 1_000_000 * NORM_STEP_NS + 999) / 1000;
	// host keepalive rewrite period, well inside the watchdog window
	localparam int unsigned KEEP_MS        = 500;
	localparam int unsigned KEEP_CYCLES    = CLK_HZ / 1000 * KEEP_MS;
	// half period of the serial clock in system clocks
	localparam int unsigned SPI_HALF       = 50;
	// modulator full-scale count and fast duty phases
	localparam logic [10:0] FULL_SCALE     = 11'h3FF;
	localparam int unsigned PWM_PHASES     = 8;
	// serial frame: 3 address bits then 11 data bits, msb first
	localparam int unsigned FRAME_BITS     = 14;
	localparam int unsigned DATA_BITS      = 11;
	localparam logic [2:0]  ADDR_CURRENT   = 3'h6;
	localparam logic [2:0]  ADDR_CHARGER   = 3'h7;
	// current register fields
	localparam int unsigned LCM_POS        = 10;
	localparam int unsigned CODE_MSB       = 9;
	// charger register fields
	localparam int unsigned SEL1_POS       = 0;
	localparam int unsigned SEL2_POS       = 1;
	// reset values
	localparam logic [10:0] CURRENT_RST    = 11'h000;
	localparam logic [1:0]  SELECT_RST     = 2'h0;
	// host register offsets (byte addresses)
	localparam logic [3:0]  OFF_CURRENT    = 4'h0;
	localparam logic [3:0]  OFF_SELECT     = 4'h4;
	localparam logic [3:0]  OFF_STATUS     = 4'h8;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// serial master states
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_LOW  = 2'b01,
		SPI_HIGH = 2'b10,
		SPI_GAP  = 2'b11
	} spi_state_t;
endpackage

// >>> rtl/charger_link.sv
`timescale 1ns/1ps
// serial write-only link from host to charger
interface charger_link;
	logic sclk;   // serial clock, idle low
	logic cs_n;   // frame select, active low
	logic mosi;   // data, msb first, sampled on sclk rise
	modport host   (output sclk, output cs_n, output mosi);
	modport device (input sclk, input cs_n, input mosi);
endinterface

// >>> rtl/charge_current_dac_watchdog.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - switch density equals code over 1023
// - low-current mode gates output at 1/8 duty
// - modulator bit gates the 1/8 duty signal
// - low-current modulator steps every 40 ms
// - low-current mode: both selected, first only
// - charging starts when a select bit set
// - watchdog restarted per charger write, expiry stops
// - host rewrites charger register within one second
// - dual charging takes feedback from second battery
// - low-current mode ignores minimum battery voltage
// - host uses low-current mode for depleted battery
// - host first selects lowest termination battery
// - host then switches to dual without stopping
// - dual: only batteries above minimum charge
// - dual: lower battery charges until voltages equal
module charge_current_dac_watchdog #(
	parameter int unsigned WDOG_LIMIT = chg_pkg::WDOG_CYCLES,    // watchdog terminal count
	parameter int unsigned LC_STEP    = chg_pkg::LC_STEP_CYCLES, // low-current step period
	parameter int unsigned NORM_STEP  = chg_pkg::NORM_STEP_CYC   // normal step period
) (
	input  wire logic  clk,
	input  wire logic  rst,
	charger_link.device link,
	input  wire logic  first_battery_above_min,
	input  wire logic  second_battery_above_min,
	input  wire logic  first_battery_lower,
	input  wire logic  second_battery_lower,
	output logic       current_switch,
	output logic       first_battery_charge_en,
	output logic       second_battery_charge_en,
	output logic       feedback_from_second,
	output logic       charging,
	output logic       low_current_active
);
	import chg_pkg::*;

	localparam int unsigned NPIN    = 7;
	localparam logic [6:0]  PIN_RST = 7'h02; // select idles high

	logic [NPIN-1:0] raw;   // asynchronous inputs
	logic [NPIN-1:0] s1;    // first stage, read only by s2
	logic [NPIN-1:0] s2;    // second stage
	logic [NPIN-1:0] s3;    // third stage
	logic [NPIN-1:0] pin;   // debounced value
	logic [NPIN-1:0] next_pin;

	assign raw = {second_battery_lower, first_battery_lower, second_battery_above_min,
		first_battery_above_min, link.mosi, link.cs_n, link.sclk};

	// per input: accept a change only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			assign next_pin[gi] = (s2[gi] == s3[gi]) ? s3[gi] : pin[gi];
		end
	endgenerate

	// three-stage synchronisers and settled copies
	always_ff @(posedge clk) begin
		if (rst) begin
			s1  <= PIN_RST;
			s2  <= PIN_RST;
			s3  <= PIN_RST;
			pin <= PIN_RST;
		end else begin
			s1  <= raw;
			s2  <= s1;
			s3  <= s2;
			pin <= next_pin;
		end
	end

	// serial receiver state
	logic                  sclk_q;      // previous settled serial clock
	logic                  cs_q;        // previous settled select
	logic [FRAME_BITS-1:0] shift;       // incoming frame
	logic [4:0]            nbits;       // bits taken this frame
	logic [DATA_BITS-1:0]  current_dac; // low-current bit plus code
	logic [1:0]            selects;     // battery select bits
	logic [31:0]           wdog;        // watchdog count
	logic                  chg_ok;      // charger register still fresh
	logic                  next_sclk_q, next_cs_q, next_chg_ok;
	logic [FRAME_BITS-1:0] next_shift;
	logic [4:0]            next_nbits;
	logic [DATA_BITS-1:0]  next_current_dac;
	logic [1:0]            next_selects;
	logic [31:0]           next_wdog;
	logic                  frame_done;  // select rose after a full frame
	logic                  chg_write;   // charger register written

	// frame capture, register writes and watchdog
	always_comb begin
		next_sclk_q      = pin[0];
		next_cs_q        = pin[1];
		next_shift       = shift;
		next_nbits       = nbits;
		next_current_dac = current_dac;
		next_selects     = selects;
		next_wdog        = wdog;
		next_chg_ok      = chg_ok;
		frame_done       = pin[1] && !cs_q && (nbits == 5'(FRAME_BITS));
		chg_write        = frame_done && (shift[FRAME_BITS-1 -: 3] == ADDR_CHARGER);
		if (pin[1]) begin
			next_nbits = 5'h00; // deselected: next frame starts fresh
		end else if (pin[0] && !sclk_q && nbits != 5'h1F) begin
			next_shift = {shift[FRAME_BITS-2:0], pin[2]};
			next_nbits = nbits + 5'h01;
		end
		if (frame_done && shift[FRAME_BITS-1 -: 3] == ADDR_CURRENT) begin
			next_current_dac = shift[DATA_BITS-1:0];
		end
		if (chg_write) begin
			next_selects = {shift[SEL2_POS], shift[SEL1_POS]};
			next_wdog    = 32'h0;
			next_chg_ok  = |{shift[SEL2_POS], shift[SEL1_POS]};
		end else if (chg_ok) begin
			if (wdog == 32'(WDOG_LIMIT - 1)) begin
				next_chg_ok = 1'b0;                         // expiry stops charging
			end else begin
				next_wdog = wdog + 32'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_q      <= 1'b0;
			cs_q        <= 1'b1;
			shift       <= '0;
			nbits       <= 5'h00;
			current_dac <= CURRENT_RST;
			selects     <= SELECT_RST;
			wdog        <= 32'h0;
			chg_ok      <= 1'b0;
		end else begin
			sclk_q      <= next_sclk_q;
			cs_q        <= next_cs_q;
			shift       <= next_shift;
			nbits       <= next_nbits;
			current_dac <= next_current_dac;
			selects     <= next_selects;
			wdog        <= next_wdog;
			chg_ok      <= next_chg_ok;
		end
	end

	// modulator state
	logic        low;           // low-current mode selected
	logic [31:0] step_cnt;      // step divider
	logic [9:0]  acc;           // accumulator, always below full scale
	logic        ds_bit;        // modulator output bit
	logic [2:0]  phase;         // fast 1/8 duty phase
	logic [31:0] next_step_cnt;
	logic [9:0]  next_acc;
	logic        next_ds_bit;
	logic [2:0]  next_phase;
	logic        step;          // one-cycle step enable
	logic [10:0] sum;

	assign low = current_dac[LCM_POS];

	// step divider, accumulator and duty phase
	always_comb begin
		next_step_cnt = step_cnt + 32'h1;
		next_acc      = acc;
		next_ds_bit   = ds_bit;
		next_phase    = phase + 3'h1;
		step          = step_cnt >= 32'(low ? LC_STEP - 1 : NORM_STEP - 1);
		sum           = {1'b0, acc} + {1'b0, current_dac[CODE_MSB:0]};
		if (step) begin
			next_step_cnt = 32'h0;
			// modulo-1023 accumulation gives exactly code/1023 density
			if (sum >= FULL_SCALE) begin
				next_acc    = 10'(sum - FULL_SCALE);
				next_ds_bit = 1'b1;
			end else begin
				next_acc    = sum[9:0];
				next_ds_bit = 1'b0;
			end
		end
		if (32'(next_phase) >= PWM_PHASES) begin
			next_phase = 3'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			step_cnt <= 32'h0;
			acc      <= 10'h000;
			ds_bit   <= 1'b0;
			phase    <= 3'h0;
		end else begin
			step_cnt <= next_step_cnt;
			acc      <= next_acc;
			ds_bit   <= next_ds_bit;
			phase    <= next_phase;
		end
	end

	// output selection
	logic [1:0] sel;        // selects still under watchdog
	logic       en1, en2;   // path enables before equalising
	logic       next_sw, next_en1, next_en2, next_fb;

	always_comb begin
		sel = selects & {2{chg_ok}};
		// low mode waives the minimum voltage, and forbids dual
		en1 = sel[0] && (low || pin[3]);
		en2 = sel[1] && (low ? !sel[0] : pin[4]);
		next_en1 = en1;
		next_en2 = en2;
		if (en1 && en2) begin
			// only the lower battery takes charge until they match
			if (pin[5]) begin
				next_en2 = 1'b0;
			end else if (pin[6]) begin
				next_en1 = 1'b0;
			end
		end
		next_fb = sel[0] && sel[1] && !low;
		if (!(en1 || en2)) begin
			next_sw = 1'b0;
		end else if (low) begin
			next_sw = ds_bit && (phase == 3'h0);
		end else begin
			next_sw = ds_bit;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			current_switch           <= 1'b0;
			first_battery_charge_en  <= 1'b0;
			second_battery_charge_en <= 1'b0;
			feedback_from_second     <= 1'b0;
			charging                 <= 1'b0;
			low_current_active       <= 1'b0;
		end else begin
			current_switch           <= next_sw;
			first_battery_charge_en  <= next_en1;
			second_battery_charge_en <= next_en2;
			feedback_from_second     <= next_fb;
			charging                 <= next_en1 || next_en2;
			low_current_active       <= low;
		end
	end
endmodule

// >>> rtl/charger_host.sv
`timescale 1ns/1ps
// host end: AXI4-Lite registers in, serial charger writes out
module charger_host #(
	parameter int unsigned KEEP_LIMIT = chg_pkg::KEEP_CYCLES, // keepalive period
	parameter int unsigned HALF       = chg_pkg::SPI_HALF     // serial half period
) (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	charger_link.host  link
);
	import chg_pkg::*;

	logic [10:0] cur_reg;   // low-current bit and current code
	logic [1:0]  sel_reg;   // battery selects
	logic        pend_cur;  // current frame waiting
	logic        pend_sel;  // charger frame waiting
	logic        busy;      // frame on the wire
	logic        wtake, rtake;
	logic [10:0] next_cur_reg;
	logic [1:0]  next_sel_reg, next_bresp, next_rresp;
	logic        next_bvalid, next_rvalid;
	logic [31:0] next_rdata;

	// one write and one read at a time: accept only with no answer pending
	assign wtake   = awvalid && wvalid && !bvalid;
	assign awready = wtake;
	assign wready  = wtake;
	assign rtake   = arvalid && !rvalid;
	assign arready = rtake;

	// register bus
	always_comb begin
		next_cur_reg = cur_reg;
		next_sel_reg = sel_reg;
		next_bvalid  = bvalid && !bready;
		next_bresp   = bresp;
		next_rvalid  = rvalid && !rready;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (wtake) begin
			next_bvalid = 1'b1;
			next_bresp  = RESP_OKAY;
			if (awaddr[3:2] == OFF_CURRENT[3:2]) begin
				// low-current bit passes straight to the device
				if (wstrb[0]) next_cur_reg[7:0] = wdata[7:0];
				if (wstrb[1]) next_cur_reg[10:8] = wdata[10:8];
			end else if (awaddr[3:2] == OFF_SELECT[3:2]) begin
				// select changes go out without a stop in between
				if (wstrb[0]) next_sel_reg = wdata[1:0];
			end else begin
				next_bresp = RESP_SLVERR; // status is read-only, rest unmapped
			end
		end
		if (rtake) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case (araddr[3:2])
				OFF_CURRENT[3:2]: next_rdata = {21'h0, cur_reg};
				OFF_SELECT[3:2]:  next_rdata = {30'h0, sel_reg};
				OFF_STATUS[3:2]:  next_rdata = {29'h0, pend_sel, pend_cur, busy};
				default: begin
					next_rdata = 32'h0;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_reg <= CURRENT_RST;
			sel_reg <= SELECT_RST;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end else begin
			cur_reg <= next_cur_reg;
			sel_reg <= next_sel_reg;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// serial master
	spi_state_t            state, next_state;
	logic [31:0]           div, next_div;     // half-period divider
	logic [31:0]           keep, next_keep;   // keepalive counter
	logic [FRAME_BITS-1:0] frame, next_frame; // bits still to send
	logic [4:0]            nbit, next_nbit;
	logic                  next_pend_cur, next_pend_sel;
	logic                  next_sclk, next_cs_n, next_mosi;
	logic                  tick;              // one-cycle half-period enable

	assign busy = (state != SPI_IDLE);

	always_comb begin
		tick          = (div == 32'(HALF - 1));
		next_div      = tick ? 32'h0 : div + 32'h1;
		next_state    = state;
		next_frame    = frame;
		next_nbit     = nbit;
		next_sclk     = link.sclk;
		next_cs_n     = link.cs_n;
		next_mosi     = link.mosi;
		next_pend_cur = pend_cur || (wtake && awaddr[3:2] == OFF_CURRENT[3:2]);
		next_pend_sel = pend_sel || (wtake && awaddr[3:2] == OFF_SELECT[3:2]);
		next_keep     = (sel_reg != 2'h0) ? keep + 32'h1 : 32'h0;
		// rewrite the charger register well inside the watchdog window
		if (keep >= 32'(KEEP_LIMIT - 1)) begin
			next_pend_sel = 1'b1;
			next_keep     = 32'h0;
		end
		case (state)
			SPI_IDLE: begin
				if (tick && (pend_cur || pend_sel)) begin
					// a write taken in this same cycle keeps its own frame pending,
					// otherwise its new value would never reach the device
					if (pend_cur) begin
						next_frame    = {ADDR_CURRENT, cur_reg};
						next_pend_cur = wtake && (awaddr[3:2] == OFF_CURRENT[3:2]);
					end else begin
						next_frame    = {ADDR_CHARGER, 9'h000, sel_reg};
						next_pend_sel = wtake && (awaddr[3:2] == OFF_SELECT[3:2]);
						next_keep     = 32'h0;
					end
					next_cs_n  = 1'b0;
					next_mosi  = next_frame[FRAME_BITS-1];
					next_nbit  = 5'h00;
					next_state = SPI_LOW;
				end
			end
			SPI_LOW: begin
				if (tick) begin
					next_sclk  = 1'b1; // device samples on this rise
					next_state = SPI_HIGH;
				end
			end
			SPI_HIGH: begin
				if (tick) begin
					next_sclk = 1'b0;
					if (nbit == 5'(FRAME_BITS - 1)) begin
						next_state = SPI_GAP;
					end else begin
						next_frame = {frame[FRAME_BITS-2:0], 1'b0};
						next_mosi  = frame[FRAME_BITS-2];
						next_nbit  = nbit + 5'h01;
						next_state = SPI_LOW;
					end
				end
			end
			SPI_GAP: begin
				// select stays high one half period before the next frame
				if (tick) begin
					next_cs_n  = 1'b1;
					next_state = SPI_IDLE;
				end
			end
			default: next_state = SPI_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= SPI_IDLE;
			div       <= 32'h0;
			keep      <= 32'h0;
			frame     <= '0;
			nbit      <= 5'h00;
			pend_cur  <= 1'b0;
			pend_sel  <= 1'b0;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			link.mosi <= 1'b0;
		end else begin
			state     <= next_state;
			div       <= next_div;
			keep      <= next_keep;
			frame     <= next_frame;
			nbit      <= next_nbit;
			pend_cur  <= next_pend_cur;
			pend_sel  <= next_pend_sel;
			link.sclk <= next_sclk;
			link.cs_n <= next_cs_n;
			link.mosi <= next_mosi;
		end
	end
endmodule

// >>> tb/charge_current_dac_watchdog_sva.sv
`timescale 1ns/1ps
// watches the serial link and the charge outputs of the device end
module charge_current_dac_watchdog_sva #(
	parameter int unsigned WDOG_LIMIT = chg_pkg::WDOG_CYCLES // watchdog terminal count
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic current_switch,
	input wire logic first_battery_charge_en,
	input wire logic second_battery_charge_en,
	input wire logic charging,
	input wire logic low_current_active
);
	import chg_pkg::*;
	logic        sclk_q;        // serial clock one cycle ago
	logic        cs_q;          // frame select one cycle ago
	logic [4:0]  rise_cnt;      // serial clock rises in the open frame
	logic [31:0] idle_cnt;      // cycles since the last frame closed
	logic        next_sclk_q;
	logic        next_cs_q;
	logic [4:0]  next_rise_cnt;
	logic [31:0] next_idle_cnt;
	logic        en_any;        // either charge path open
	assign en_any = first_battery_charge_en | second_battery_charge_en;
	// frame bit counter and quiet-link counter; the latter saturates so a long idle never wraps
	always_comb begin
		next_sclk_q   = sclk;
		next_cs_q     = cs_n;
		next_rise_cnt = cs_n ? 5'h00 : rise_cnt + 5'(sclk & ~sclk_q);
		next_idle_cnt = (cs_n && !cs_q) ? 32'h0 : idle_cnt + 32'(idle_cnt != 32'hFFFFFFFF);
	end
	// helper registers only
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_q   <= 1'b0;
			cs_q     <= 1'b1;
			rise_cnt <= 5'h00;
			idle_cnt <= 32'h0;
		end else begin
			sclk_q   <= next_sclk_q;
			cs_q     <= next_cs_q;
			rise_cnt <= next_rise_cnt;
			idle_cnt <= next_idle_cnt;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a low-current pulse is followed by seven quiet cycles
	sequence s_quiet7;
		!current_switch [*7];
	endsequence
	a_link_idle: assert property (cs_n |-> !sclk)
		else $error("serial clock moved outside a frame");
	a_frame_bits: assert property ($rose(cs_n) |-> rise_cnt == 5'(FRAME_BITS))
		else $error("frame closed with a wrong bit count");
	a_frame_gap: assert property ($rose(cs_n) |=> cs_n [*3])
		else $error("frame select gap too short");
	a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("data changed while serial clock high");
	a_low_no_dual: assert property (low_current_active && $past(low_current_active, 2)
		|-> !(first_battery_charge_en && second_battery_charge_en))
		else $error("dual charge while in low-current mode");
	a_low_duty: assert property ($rose(current_switch) && low_current_active && $past(low_current_active)
		|=> s_quiet7)
		else $error("low-current pulse wider than one in eight");
	a_switch_gated: assert property (!en_any && !$past(en_any) |-> !current_switch)
		else $error("switch closed with no charge path");
	a_charging_flag: assert property ($stable(en_any) |-> charging == en_any)
		else $error("charging flag disagrees with path enables");
	a_watchdog_stop: assert property (idle_cnt > WDOG_LIMIT + 8 |-> !en_any)
		else $error("charging outlived the watchdog");
endmodule

// >>> tb/charge_current_dac_watchdog_bench.sv
`timescale 1ns/1ps
module charge_current_dac_watchdog_bench;
	import chg_pkg::*;
	localparam int unsigned WDOG = 2000; // shortened watchdog keeps the run brief
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic        host_rst = 1'b1;  // separate so the host can fall silent
	logic [3:0]  awaddr   = 4'h0;
	logic        awvalid  = 1'b0;
	logic [31:0] wdata    = 32'h0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic [3:0]  araddr   = 4'h0;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic        min1     = 1'b0;  // first battery above minimum
	logic        min2     = 1'b0;  // second battery above minimum
	logic        low1     = 1'b0;  // first battery lower
	logic        low2     = 1'b0;  // second battery lower
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        current_switch, en1, en2, fb2, charging, low_act;
	logic [9:0]  codes [3] = '{10'h000, 10'h155, 10'h3FF};
	int          mismatches = 0;
	int          n_tests = 0;
	int          c;
	int          n;
	charger_link u_charger_link ();
	charger_host #(.KEEP_LIMIT(500), .HALF(4)) u_charger_host (.clk(clk), .rst(host_rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .link(u_charger_link));
	charge_current_dac_watchdog #(.WDOG_LIMIT(WDOG), .LC_STEP(64), .NORM_STEP(1)) u_charge_current_dac_watchdog (
		.clk(clk), .rst(rst), .link(u_charger_link), .first_battery_above_min(min1),
		.second_battery_above_min(min2), .first_battery_lower(low1), .second_battery_lower(low2),
		.current_switch(current_switch), .first_battery_charge_en(en1), .second_battery_charge_en(en2),
		.feedback_from_second(fb2), .charging(charging), .low_current_active(low_act));
	charge_current_dac_watchdog_sva #(.WDOG_LIMIT(WDOG)) u_sva (.clk(clk), .rst(rst),
		.sclk(u_charger_link.sclk), .cs_n(u_charger_link.cs_n), .mosi(u_charger_link.mosi),
		.current_switch(current_switch), .first_battery_charge_en(en1), .second_battery_charge_en(en2),
		.charging(charging), .low_current_active(low_act));
	// 100 MHz system clock
	initial begin
		forever #5 clk = ~clk;
	end
	// verdict and end of run, also reached by any expired wait
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic guard(input int k, input string what);
		if (k >= 1000) begin
			mismatches++;
			$display("BAD %s expected handshake seen timeout", what);
			close_out();
		end
	endtask
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one write; address and data offered together, ready sampled where settled
	task automatic write_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(negedge clk);
		for (k = 0; awready !== 1'b1 && k < 1000; k++) @(negedge clk);
		guard(k, "awready");
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(negedge clk);
		for (k = 0; bvalid !== 1'b1 && k < 1000; k++) @(negedge clk);
		guard(k, "bvalid");
		cmp_word("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic read_word(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge clk);
		for (k = 0; arready !== 1'b1 && k < 1000; k++) @(negedge clk);
		guard(k, "arready");
		@(posedge clk);
		arvalid <= 1'b0;
		@(negedge clk);
		for (k = 0; rvalid !== 1'b1 && k < 1000; k++) @(negedge clk);
		guard(k, "rvalid");
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic read_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		read_word(a, d, r);
		cmp_word("rdata", ed, d);
		cmp_word("rresp", {30'h0, er}, {30'h0, r});
	endtask
	// polls status until both frames have gone, then lets synchronisers settle
	task automatic host_idle();
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		for (k = 0; k < 1000; k++) begin
			read_word(OFF_STATUS, d, r);
			if (d === 32'h0) break;
		end
		guard(k, "status");
		// longer than one low-current step, so the old modulator bit has flushed
		repeat (80) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic count_sw(input int len, output int cnt);
		cnt = 0;
		repeat (len) begin
			@(negedge clk);
			if (current_switch === 1'b1) cnt++;
		end
	endtask
	// longest train of pulses spaced exactly one duty period apart
	task automatic max_run(input int len, output int best);
		int last;
		int run;
		best = 0;
		last = -100;
		run = 0;
		for (int i = 0; i < len; i++) begin
			@(negedge clk);
			if (current_switch === 1'b1) begin
				run = (i - last == PWM_PHASES) ? run + 1 : 1;
				last = i;
				if (run > best) best = run;
			end
		end
	endtask
	task automatic paths(input logic e1, input logic e2);
		repeat (10) @(posedge clk);
		@(negedge clk);
		cmp_bit("en1", e1, en1);
		cmp_bit("en2", e2, en2);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		host_rst <= 1'b0;
		@(negedge clk);
		cmp_bit("charging", 1'b0, charging);
		read_chk(OFF_CURRENT, 32'h0, RESP_OKAY);
		read_chk(OFF_SELECT, 32'h0, RESP_OKAY);
		read_chk(4'hC, 32'h0, RESP_SLVERR);
		write_chk(OFF_STATUS, 32'h1, RESP_SLVERR);
		write_chk(4'hC, 32'h1, RESP_SLVERR);
		$display("test registers done");
		min1 <= 1'b1;
		min2 <= 1'b1;
		write_chk(OFF_SELECT, 32'h1, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			write_chk(OFF_CURRENT, {22'h0, codes[i]}, RESP_OKAY);
			host_idle();
			count_sw(1023, c);
			cmp_word("pulses", {22'h0, codes[i]}, 32'(c));
		end
		cmp_bit("charging", 1'b1, charging);
		cmp_bit("feedback", 1'b0, fb2);
		$display("test density done");
		write_chk(OFF_SELECT, 32'h3, RESP_OKAY);
		host_idle();
		cmp_bit("feedback", 1'b1, fb2);
		paths(1'b1, 1'b1);
		@(posedge clk);
		low1 <= 1'b1;
		paths(1'b1, 1'b0);
		@(posedge clk);
		low1 <= 1'b0;
		low2 <= 1'b1;
		paths(1'b0, 1'b1);
		@(posedge clk);
		low2 <= 1'b0;
		min2 <= 1'b0;
		paths(1'b1, 1'b0);
		$display("test dual done");
		@(posedge clk);
		min1 <= 1'b0;
		write_chk(OFF_CURRENT, 32'h7FF, RESP_OKAY);
		host_idle();
		cmp_bit("low", 1'b1, low_act);
		paths(1'b1, 1'b0);
		count_sw(512, c);
		cmp_word("pulses", 32'd64, 32'(c));
		write_chk(OFF_CURRENT, 32'h555, RESP_OKAY);
		host_idle();
		max_run(1024, c);
		cmp_word("train", 32'(PWM_PHASES), 32'(c));
		write_chk(OFF_CURRENT, 32'h400, RESP_OKAY);
		host_idle();
		count_sw(512, c);
		cmp_word("pulses", 32'h0, 32'(c));
		$display("test low current done");
		write_chk(OFF_CURRENT, 32'h7FF, RESP_OKAY);
		host_idle();
		for (n = 0; u_charger_link.cs_n !== 1'b0 && n < 1000; n++) @(negedge clk);
		guard(n, "frame start");
		for (n = 0; u_charger_link.cs_n !== 1'b1 && n < 1000; n++) @(negedge clk);
		guard(n, "frame end");
		@(posedge clk);
		host_rst <= 1'b1;
		repeat (1950) @(posedge clk);
		@(negedge clk);
		cmp_bit("charging", 1'b1, charging);
		repeat (100) @(posedge clk);
		@(negedge clk);
		cmp_bit("charging", 1'b0, charging);
		@(posedge clk);
		host_rst <= 1'b0;
		write_chk(OFF_SELECT, 32'h2, RESP_OKAY);
		host_idle();
		cmp_bit("charging", 1'b1, charging);
		cmp_bit("en2", 1'b1, en2);
		$display("test watchdog done");
		close_out();
	end
endmodule
